// >>> hdl/dma_irq_ctrl.sv
// Completion interrupt controller for a 64-channel DMA channel controller.
// Assumes completion reports and the register port run on clk.
`timescale 1ns/1ns
module dma_irq_ctrl (
  input  wire logic                              clk,                 // 50 MHz clock.
  input  wire logic                              reset,               // Sync reset, high.
  input  wire logic                              clk_en,              // Freezes state when low.
  input  wire logic                              done_valid,          // Completion report.
  input  wire logic                              done_final,          // Final vs partial.
  input  wire irq_pkg::word_t                    channel_config_word, // Transfer config.
  input  wire irq_pkg::addr_t                    reg_addr,            // Register byte address.
  input  wire irq_pkg::word_t                    reg_wdata,           // Write data.
  input  wire logic                              reg_wr,              // Write strobe.
  input  wire logic                              reg_rd,              // Read strobe.
  output irq_pkg::word_t                         reg_rdata,           // Read data, next cycle.
  output logic [irq_pkg::NUM_REGIONS-1:0]        region_done_irq,     // Region pulses.
  output logic                                   all_regions_done_irq // Global pulse.
);
  import irq_pkg::*;

  irq_link_if link ();

  chan_vec_t pend_r;
  chan_vec_t en_r;
  chan_vec_t mask_r [NUM_REGIONS];
  word_t     rdata_r;
  chan_vec_t clr_vec;
  chan_vec_t eset_vec;
  chan_vec_t eclr_vec;
  logic      mask_hit;
  logic [REGION_W-1:0] mask_region;
  logic      mask_high;
  word_t     read_mux;

  // Places a word in the low or high half of a channel vector.
  function automatic chan_vec_t half_vec(input word_t d, input logic hi);
    return hi ? {d, WORD_ZERO} : {WORD_ZERO, d};
  endfunction

  // Decodes a write to a low/high pair of pseudo registers into a channel vector.
  function automatic chan_vec_t strobe_vec(input logic wr, input addr_t a, input addr_t lo,
                                           input addr_t hi, input word_t d);
    if (wr && a == lo) begin
      return half_vec(d, 1'b0);
    end else if (wr && a == hi) begin
      return half_vec(d, 1'b1);
    end
    return CHAN_ZERO;
  endfunction

  done_decode u_decode (
    .done_valid          (done_valid),
    .done_final          (done_final),
    .channel_config_word (channel_config_word),
    .link                (link.decoder)
  );

  irq_pulse u_pulse (
    .clk    (clk),
    .reset  (reset),
    .clk_en (clk_en),
    .link   (link.shaper)
  );

  // Pseudo register writes become per-channel vectors.
  assign clr_vec  = strobe_vec(reg_wr, reg_addr, PENDING_CLEAR_LOW, PENDING_CLEAR_HIGH,
                               reg_wdata);
  assign eset_vec = strobe_vec(reg_wr, reg_addr, ENABLE_SET_LOW, ENABLE_SET_HIGH, reg_wdata);
  assign eclr_vec = strobe_vec(reg_wr, reg_addr, ENABLE_CLEAR_LOW, ENABLE_CLEAR_HIGH,
                               reg_wdata);

  // Region mask words: eight regions, low word then high word each.
  assign mask_hit    = reg_wr && reg_addr >= MASK_BASE && reg_addr <= MASK_LAST;
  assign mask_region = reg_addr[MASK_REGION_LSB +: REGION_W];
  assign mask_high   = reg_addr[MASK_HALF_BIT];

  // A write of one to the reassert bit asks for a fresh evaluation.
  assign link.reeval = reg_wr && reg_addr == PENDING_REASSERT_REG
                       && reg_wdata[REASSERT_BIT];

  // Pending flags: set by completions, cleared only by pending-clear writes.
  always_ff @(posedge clk) begin
    if (reset) begin
      pend_r <= CHAN_ZERO;
    end else if (clk_en) begin
      pend_r <= (pend_r & ~clr_vec) | link.set_vec;
    end
  end

  // Enable flags change only through the set and clear pseudo registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      en_r <= CHAN_ZERO;
    end else if (clk_en) begin
      en_r <= (en_r | eset_vec) & ~eclr_vec;
    end
  end

  // Per-region channel masks, written directly.
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int n = 0; n < NUM_REGIONS; n++) begin
        mask_r[n] <= CHAN_ZERO;
      end
    end else if (clk_en && mask_hit) begin
      if (mask_high) begin
        mask_r[mask_region][NUM_CH-1:HALF] <= reg_wdata;
      end else begin
        mask_r[mask_region][HALF-1:0] <= reg_wdata;
      end
    end
  end

  // Line levels: each region gated by its mask, the global line by none.
  always_comb begin
    for (int n = 0; n < NUM_REGIONS; n++) begin
      link.level[n] = |(pend_r & en_r & mask_r[n]);
    end
    link.level[GLOBAL_LINE] = |(pend_r & en_r);
  end

  // Readback mux; pseudo registers and unmapped addresses read as zero.
  always_comb begin
    read_mux = WORD_ZERO;
    if (reg_addr >= MASK_BASE && reg_addr <= MASK_LAST) begin
      read_mux = mask_high ? mask_r[mask_region][NUM_CH-1:HALF]
                           : mask_r[mask_region][HALF-1:0];
    end else begin
      unique case (reg_addr)
        PENDING_FLAGS_LOW:      read_mux = pend_r[HALF-1:0];
        PENDING_FLAGS_HIGH:     read_mux = pend_r[NUM_CH-1:HALF];
        COMPLETION_ENABLE_LOW:  read_mux = en_r[HALF-1:0];
        COMPLETION_ENABLE_HIGH: read_mux = en_r[NUM_CH-1:HALF];
        default:                read_mux = WORD_ZERO;
      endcase
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= WORD_ZERO;
    end else if (clk_en) begin
      rdata_r <= reg_rd ? read_mux : WORD_ZERO;
    end
  end

  assign reg_rdata            = rdata_r;
  assign region_done_irq      = link.pulse[NUM_REGIONS-1:0];
  assign all_regions_done_irq = link.pulse[GLOBAL_LINE];

  // Checks on the completion, pending and enable paths.
  logic [CODE_W-1:0] code_w;
  assign code_w = channel_config_word[CODE_LSB +: CODE_W];

  sequence s_final_enabled;
    clk_en && done_valid && done_final && channel_config_word[FINAL_EN_BIT];
  endsequence

  sequence s_partial_enabled;
    clk_en && done_valid && !done_final && channel_config_word[PARTIAL_EN_BIT];
  endsequence

  property p_final_sets;
    @(posedge clk) disable iff (reset)
    s_final_enabled |=> pend_r[$past(code_w)];
  endproperty
  a_final_sets: assert property (p_final_sets)
    else $error("Enabled final completion did not set its pending bit.");

  property p_final_blocked;
    @(posedge clk) disable iff (reset)
    clk_en && done_valid && done_final && !channel_config_word[FINAL_EN_BIT]
      && !pend_r[code_w] |=> !pend_r[$past(code_w)];
  endproperty
  a_final_blocked: assert property (p_final_blocked)
    else $error("Disabled final completion set a pending bit.");

  property p_partial_sets;
    @(posedge clk) disable iff (reset)
    s_partial_enabled |=> pend_r[$past(code_w)];
  endproperty
  a_partial_sets: assert property (p_partial_sets)
    else $error("Enabled partial completion did not set its pending bit.");

  property p_partial_blocked;
    @(posedge clk) disable iff (reset)
    clk_en && done_valid && !done_final && !channel_config_word[PARTIAL_EN_BIT]
      && !pend_r[code_w] |=> !pend_r[$past(code_w)];
  endproperty
  a_partial_blocked: assert property (p_partial_blocked)
    else $error("Disabled partial completion set a pending bit.");

  property p_enable_set;
    @(posedge clk) disable iff (reset)
    clk_en && reg_wr && reg_addr == ENABLE_SET_LOW
      |=> (en_r[HALF-1:0] & $past(reg_wdata)) == $past(reg_wdata);
  endproperty
  a_enable_set: assert property (p_enable_set)
    else $error("Enable-set write did not set enable bits.");

  property p_enable_clear;
    @(posedge clk) disable iff (reset)
    clk_en && reg_wr && reg_addr == ENABLE_CLEAR_HIGH
      |=> (en_r[NUM_CH-1:HALF] & $past(reg_wdata)) == WORD_ZERO
          && (en_r[NUM_CH-1:HALF] | $past(reg_wdata)) == ($past(en_r[NUM_CH-1:HALF])
          | $past(reg_wdata));
  endproperty
  a_enable_clear: assert property (p_enable_clear)
    else $error("Enable-clear write disturbed other bits or left bits set.");

  property p_pending_clear;
    @(posedge clk) disable iff (reset)
    clk_en && reg_wr && reg_addr == PENDING_CLEAR_LOW
      |=> (pend_r[HALF-1:0] & $past(reg_wdata) & ~$past(link.set_vec[HALF-1:0]))
          == WORD_ZERO;
  endproperty
  a_pending_clear: assert property (p_pending_clear)
    else $error("Pending-clear write left a bit set.");

  property p_set_wins;
    @(posedge clk) disable iff (reset)
    clk_en && (|(link.set_vec & clr_vec)) |=> (|(pend_r & $past(link.set_vec)));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Completion lost against a same-cycle pending clear.");

  property p_global_unmasked;
    @(posedge clk) disable iff (reset)
    clk_en && !link.level[GLOBAL_LINE] ##1 clk_en && (|(pend_r & en_r))
      |=> all_regions_done_irq;
  endproperty
  a_global_unmasked: assert property (p_global_unmasked)
    else $error("Global line did not pulse on first enabled pending bit.");

  // Checks on the register side, the clock enable and pulse shaping.
  property p_enable_set_high;
    @(posedge clk) disable iff (reset)
    clk_en && reg_wr && reg_addr == ENABLE_SET_HIGH
      |=> (en_r[NUM_CH-1:HALF] & $past(reg_wdata)) == $past(reg_wdata);
  endproperty
  a_enable_set_high: assert property (p_enable_set_high)
    else $error("Enable-set high write did not set enable bits.");

  property p_enable_clear_low;
    @(posedge clk) disable iff (reset)
    clk_en && reg_wr && reg_addr == ENABLE_CLEAR_LOW
      |=> (en_r[HALF-1:0] & $past(reg_wdata)) == WORD_ZERO
          && (en_r[HALF-1:0] | $past(reg_wdata)) == ($past(en_r[HALF-1:0])
          | $past(reg_wdata));
  endproperty
  a_enable_clear_low: assert property (p_enable_clear_low)
    else $error("Enable-clear low write disturbed other bits or left bits set.");

  property p_pending_clear_high;
    @(posedge clk) disable iff (reset)
    clk_en && reg_wr && reg_addr == PENDING_CLEAR_HIGH
      |=> (pend_r[NUM_CH-1:HALF] & $past(reg_wdata)
           & ~$past(link.set_vec[NUM_CH-1:HALF])) == WORD_ZERO;
  endproperty
  a_pending_clear_high: assert property (p_pending_clear_high)
    else $error("Pending-clear high write left a bit set.");

  property p_pend_sticky;
    @(posedge clk) disable iff (reset)
    clk_en |=> ($past(pend_r) & ~$past(clr_vec) & ~pend_r) == CHAN_ZERO;
  endproperty
  a_pend_sticky: assert property (p_pend_sticky)
    else $error("Pending bit dropped without a pending-clear write.");

  property p_pend_only_set;
    @(posedge clk) disable iff (reset)
    clk_en |=> (pend_r & ~$past(pend_r) & ~$past(link.set_vec)) == CHAN_ZERO;
  endproperty
  a_pend_only_set: assert property (p_pend_only_set)
    else $error("Pending bit rose without an enabled completion.");

  property p_enable_hold;
    @(posedge clk) disable iff (reset)
    clk_en && !reg_wr |=> $stable(en_r);
  endproperty
  a_enable_hold: assert property (p_enable_hold)
    else $error("Enable bits changed without a set or clear write.");

  property p_mask_write;
    @(posedge clk) disable iff (reset)
    clk_en && mask_hit && !mask_high
      |=> mask_r[$past(mask_region)][HALF-1:0] == $past(reg_wdata);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("Region mask write did not land.");

  property p_frozen;
    @(posedge clk) disable iff (reset)
    !clk_en |=> $stable(pend_r) && $stable(en_r) && $stable(rdata_r)
                && $stable(link.pulse);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("State moved while the clock enable was low.");

  property p_rdata_idle;
    @(posedge clk) disable iff (reset)
    clk_en && !reg_rd |=> reg_rdata == WORD_ZERO;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("Read data stood outside the cycle after a read.");

  property p_rdata_pending;
    @(posedge clk) disable iff (reset)
    clk_en && reg_rd && reg_addr == PENDING_FLAGS_LOW
      |=> reg_rdata == $past(pend_r[HALF-1:0]);
  endproperty
  a_rdata_pending: assert property (p_rdata_pending)
    else $error("Pending low read returned the wrong word.");

  property p_reassert_idle;
    @(posedge clk) disable iff (reset)
    clk_en && link.reeval && !(|link.level) |=> !(|link.pulse);
  endproperty
  a_reassert_idle: assert property (p_reassert_idle)
    else $error("Reassert with no pending work gave a pulse.");

  property p_global_no_repulse;
    @(posedge clk) disable iff (reset)
    clk_en && link.level[GLOBAL_LINE] ##1 clk_en && link.level[GLOBAL_LINE] && !link.reeval
      |=> !all_regions_done_irq;
  endproperty
  a_global_no_repulse: assert property (p_global_no_repulse)
    else $error("Global line pulsed again while work was still pending.");
endmodule

// >>> hdl/irq_pkg.sv
// Constants and types shared by the DMA completion interrupt logic.
// Assumes one 50 MHz clock and a plain word-wide register port.
package irq_pkg;

  // Channel, region and line counts.
  localparam int NUM_CH      = 64;
  localparam int HALF        = 32;
  localparam int NUM_REGIONS = 8;
  localparam int NUM_LINES   = NUM_REGIONS + 1;
  localparam int GLOBAL_LINE = NUM_REGIONS;
  localparam int CODE_W      = 6;

  // Field positions inside the channel configuration word.
  localparam int CODE_LSB       = 12;
  localparam int FINAL_EN_BIT   = 20;
  localparam int PARTIAL_EN_BIT = 21;

  // Bit of the reassert register that triggers a fresh evaluation.
  localparam int REASSERT_BIT = 0;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  typedef logic [NUM_CH-1:0] chan_vec_t;
  typedef logic [DATA_W-1:0] word_t;
  typedef logic [ADDR_W-1:0] addr_t;

  // Register byte offsets.
  localparam addr_t PENDING_FLAGS_LOW      = 8'h00;
  localparam addr_t PENDING_FLAGS_HIGH     = 8'h04;
  localparam addr_t COMPLETION_ENABLE_LOW  = 8'h08;
  localparam addr_t COMPLETION_ENABLE_HIGH = 8'h0C;
  localparam addr_t PENDING_CLEAR_LOW      = 8'h10;
  localparam addr_t PENDING_CLEAR_HIGH     = 8'h14;
  localparam addr_t ENABLE_SET_LOW         = 8'h18;
  localparam addr_t ENABLE_SET_HIGH        = 8'h1C;
  localparam addr_t ENABLE_CLEAR_LOW       = 8'h20;
  localparam addr_t ENABLE_CLEAR_HIGH      = 8'h24;
  localparam addr_t PENDING_REASSERT_REG   = 8'h28;
  localparam addr_t MASK_BASE              = 8'h40;
  localparam addr_t MASK_LAST              = 8'h7C;

  // Mask word address fields: region index and low/high half.
  localparam int MASK_REGION_LSB = 3;
  localparam int REGION_W        = 3;
  localparam int MASK_HALF_BIT   = 2;

  // Reset values.
  localparam chan_vec_t CHAN_ZERO = 64'h0000_0000_0000_0000;
  localparam word_t     WORD_ZERO = 32'h0000_0000;

endpackage

// >>> hdl/irq_link_if.sv
// Interface between the interrupt core, its completion decoder and its pulse shaper.
// Assumes all parties run on the same clock.
`timescale 1ns/1ns
interface irq_link_if;
  import irq_pkg::*;

  chan_vec_t              set_vec;  // One-hot pending set request.
  logic [NUM_LINES-1:0]   level;    // Enabled pending level per line.
  logic                   reeval;   // Reassert trigger pulse.
  logic [NUM_LINES-1:0]   pulse;    // Interrupt pulse per line.

  modport decoder (output set_vec);
  modport shaper  (input level, input reeval, output pulse);
  modport core    (input set_vec, input pulse, output level, output reeval);
endinterface

// >>> hdl/done_decode.sv
// Turns one completion report into a one-hot pending set vector.
// Assumes the completion report comes from logic on the same clock.
`timescale 1ns/1ns
module done_decode (
  input  wire logic          done_valid,           // Completion report strobe.
  input  wire logic          done_final,           // High for final, low for partial.
  input  wire irq_pkg::word_t channel_config_word, // Configuration of the transfer.
  irq_link_if.decoder        link                  // Set vector toward the core.
);
  import irq_pkg::*;

  logic [CODE_W-1:0] completion_code;
  logic              irq_en;

  // One field names the channel for both kinds of completion.
  assign completion_code = channel_config_word[CODE_LSB +: CODE_W];

  // Each kind of completion has its own enable bit.
  assign irq_en = done_final ? channel_config_word[FINAL_EN_BIT]
                             : channel_config_word[PARTIAL_EN_BIT];

  // Codes 0-31 land in the low half, 32-63 in the high half.
  assign link.set_vec = (done_valid && irq_en) ? (CHAN_ZERO | (64'h1 << completion_code))
                                               : CHAN_ZERO;
endmodule

// >>> hdl/irq_pulse.sv
// Shapes enabled pending levels into one-cycle interrupt pulses.
// Assumes levels and the reassert trigger come from the same clock.
`timescale 1ns/1ns
module irq_pulse (
  input  wire logic clk,    // System clock.
  input  wire logic reset,  // Synchronous reset, active high.
  input  wire logic clk_en, // Freezes all state while low.
  irq_link_if.shaper link   // Levels in, pulses out.
);
  import irq_pkg::*;

  logic [NUM_LINES-1:0] level_prev_r;
  logic [NUM_LINES-1:0] pulse_r;

  // A pulse leaves on a rise from empty, or on reassert while still set.
  always_ff @(posedge clk) begin
    if (reset) begin
      level_prev_r <= '0;
      pulse_r      <= '0;
    end else if (clk_en) begin
      level_prev_r <= link.level;
      pulse_r      <= (link.level & ~level_prev_r)
                    | ({NUM_LINES{link.reeval}} & link.level);
    end
  end

  assign link.pulse = pulse_r;

  sequence s_reassert;
    clk_en && link.reeval && (|link.level);
  endsequence

  property p_reassert_pulse;
    @(posedge clk) disable iff (reset)
    s_reassert |=> (|pulse_r);
  endproperty
  a_reassert_pulse: assert property (p_reassert_pulse)
    else $error("Reassert with pending work gave no pulse.");

  property p_no_repulse;
    @(posedge clk) disable iff (reset)
    clk_en && !link.reeval && (level_prev_r[0] && link.level[0]) |=> !pulse_r[0];
  endproperty
  a_no_repulse: assert property (p_no_repulse)
    else $error("Pulse emitted while earlier work still pending.");
endmodule

// >>> sim/irq_sink.sv
// Pulse counter that stands in for the processor's interrupt controller.
// Assumes one-cycle pulses on clk; line NUM_REGIONS is the global line.
`timescale 1ns/1ns
module irq_sink (
  input  wire logic                          clk,   // System clock.
  input  wire logic                          reset, // Sync reset, high.
  input  wire logic [irq_pkg::NUM_LINES-1:0] lines, // Region lines, global on top.
  output int                                 cnt [irq_pkg::NUM_LINES] // Pulses per line.
);
  import irq_pkg::*;

  // Every edge that sees a line high counts as one interrupt taken.
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_LINES; i++) begin
      if (reset) begin
        cnt[i] <= 0;
      end else if (lines[i]) begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the DMA completion interrupt controller.
// Assumes the register map and config bit positions of irq_pkg.
`timescale 1ns/1ns
module testbench;
  import irq_pkg::*;
  logic                   clk                 = 1'b0;
  logic                   reset               = 1'b1;
  logic                   done_valid          = 1'b0;
  logic                   done_final          = 1'b0;
  word_t                  channel_config_word = WORD_ZERO;
  addr_t                  reg_addr            = 8'h00;
  word_t                  reg_wdata           = WORD_ZERO;
  logic                   reg_wr              = 1'b0;
  logic                   reg_rd              = 1'b0;
  logic                   clk_en              = 1'b1;
  word_t                  reg_rdata;
  logic [NUM_REGIONS-1:0] region_done_irq;
  logic                   all_regions_done_irq;
  int                     cnt [NUM_LINES];
  int                     exp_cnt [NUM_LINES];
  int                     err_total = 0;
  int                     tests_run = 0;

  // Free-running 50 MHz clock.
  always #10 clk = ~clk;

  dma_irq_ctrl DUT (.clk(clk), .reset(reset), .clk_en(clk_en), .done_valid(done_valid),
    .done_final(done_final), .channel_config_word(channel_config_word),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .region_done_irq(region_done_irq),
    .all_regions_done_irq(all_regions_done_irq));

  irq_sink sink (.clk(clk), .reset(reset), .lines({all_regions_done_irq, region_done_irq}),
    .cnt(cnt));

  // Word comparison for register reads.
  task automatic chk_word(input string what, input word_t exp, input word_t got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits for pulses to land, then compares every line's count.
  task automatic chk_cnt(input string what);
    repeat (3) @(posedge clk);
    #1;
    for (int i = 0; i < NUM_LINES; i++) begin
      tests_run++;
      if (cnt[i] !== exp_cnt[i]) begin
        err_total++;
        $display("mismatch %s line %0d expected %0d seen %0d", what, i, exp_cnt[i], cnt[i]);
      end
    end
  endtask

  // One-cycle register write.
  task automatic wr(input addr_t a, input word_t d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle read; data are sampled in the cycle after the strobe.
  task automatic rd_chk(input string what, input addr_t a, input word_t exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk_word(what, exp, reg_rdata);
  endtask

  // Builds a configuration word from code and the two enables.
  function automatic word_t cfg(input int code, input logic fe, input logic pe);
    word_t w;
    w = WORD_ZERO;
    w[CODE_LSB +: CODE_W] = code[CODE_W-1:0];
    w[FINAL_EN_BIT] = fe;
    w[PARTIAL_EN_BIT] = pe;
    return w;
  endfunction

  // One completion report.
  task automatic done(input word_t w, input logic fin);
    @(posedge clk);
    done_valid <= 1'b1;
    done_final <= fin;
    channel_config_word <= w;
    @(posedge clk);
    done_valid <= 1'b0;
  endtask

  // Reset values and refused reads.
  task automatic t_reset();
    rd_chk("pending low", PENDING_FLAGS_LOW, WORD_ZERO);
    rd_chk("enable high", COMPLETION_ENABLE_HIGH, WORD_ZERO);
    rd_chk("mask0 low", MASK_BASE, WORD_ZERO);
    rd_chk("unmapped", 8'h30, WORD_ZERO);
    rd_chk("write only", ENABLE_SET_LOW, WORD_ZERO);
  endtask

  // Enable set and clear pseudo words, then region masks.
  task automatic t_enable();
    wr(ENABLE_SET_LOW, 32'h0000_00E0);
    wr(ENABLE_CLEAR_LOW, 32'h0000_0040);
    wr(ENABLE_SET_HIGH, 32'h0000_0101);
    wr(ENABLE_CLEAR_HIGH, 32'h0000_0001);
    rd_chk("enable low", COMPLETION_ENABLE_LOW, 32'h0000_00A0);
    rd_chk("enable high", COMPLETION_ENABLE_HIGH, 32'h0000_0100);
    wr(MASK_BASE, 32'hFFFF_FF7F);
    wr(MASK_BASE + 8'h04, 32'hFFFF_FFFF);
    wr(MASK_BASE + 8'h18, 32'h0000_0080);
    rd_chk("mask3 low", MASK_BASE + 8'h18, 32'h0000_0080);
    @(posedge clk);
    #1;
    chk_word("rdata drops", WORD_ZERO, reg_rdata);
  endtask

  // Completions whose own kind of enable is off must flag nothing.
  task automatic t_refuse();
    done(cfg(5, 1'b0, 1'b1), 1'b1);
    done(cfg(5, 1'b1, 1'b0), 1'b0);
    rd_chk("pending low", PENDING_FLAGS_LOW, WORD_ZERO);
    chk_cnt("refused");
  endtask

  // Final, partial and disabled-channel completions.
  task automatic t_flag();
    done(cfg(5, 1'b1, 1'b0), 1'b1);
    exp_cnt[0]++;
    exp_cnt[GLOBAL_LINE]++;
    chk_cnt("first final");
    done(cfg(40, 1'b0, 1'b1), 1'b0);
    done(cfg(6, 1'b1, 1'b0), 1'b1);
    rd_chk("pending low", PENDING_FLAGS_LOW, 32'h0000_0060);
    rd_chk("pending high", PENDING_FLAGS_HIGH, 32'h0000_0100);
    chk_cnt("no repulse");
  endtask

  // Reassert with work left, service loop, reassert when idle.
  task automatic t_reassert();
    wr(PENDING_REASSERT_REG, 32'h0000_0001);
    exp_cnt[0]++;
    exp_cnt[GLOBAL_LINE]++;
    chk_cnt("reassert busy");
    rd_chk("pending kept", PENDING_FLAGS_LOW, 32'h0000_0060);
    wr(PENDING_CLEAR_LOW, 32'h0000_0060);
    wr(PENDING_CLEAR_HIGH, 32'h0000_0100);
    rd_chk("pending low", PENDING_FLAGS_LOW, WORD_ZERO);
    rd_chk("pending high", PENDING_FLAGS_HIGH, WORD_ZERO);
    wr(PENDING_REASSERT_REG, 32'h0000_0001);
    chk_cnt("reassert idle");
  endtask

  // A channel owned by region 3 only pulses region 3 and the global line.
  task automatic t_region();
    done(cfg(7, 1'b1, 1'b0), 1'b1);
    exp_cnt[3]++;
    exp_cnt[GLOBAL_LINE]++;
    chk_cnt("region three");
    wr(PENDING_CLEAR_LOW, 32'h0000_0080);
  endtask

  // Completion and pending-clear on the same bit in the same cycle.
  task automatic t_collide();
    @(posedge clk);
    done_valid <= 1'b1;
    done_final <= 1'b1;
    channel_config_word <= cfg(5, 1'b1, 1'b0);
    reg_wr <= 1'b1;
    reg_addr <= PENDING_CLEAR_LOW;
    reg_wdata <= 32'h0000_0020;
    @(posedge clk);
    done_valid <= 1'b0;
    reg_wr <= 1'b0;
    rd_chk("set wins", PENDING_FLAGS_LOW, 32'h0000_0020);
    exp_cnt[0]++;
    exp_cnt[GLOBAL_LINE]++;
    chk_cnt("after collide");
  endtask

  // Clock enable low: a write and a completion must leave no trace.
  task automatic t_freeze();
    @(posedge clk);
    clk_en <= 1'b0;
    wr(ENABLE_SET_LOW, 32'h0000_0100);
    done(cfg(7, 1'b1, 1'b0), 1'b1);
    @(posedge clk);
    clk_en <= 1'b1;
    rd_chk("frozen enable", COMPLETION_ENABLE_LOW, 32'h0000_00A0);
    rd_chk("frozen pending", PENDING_FLAGS_LOW, 32'h0000_0020);
    chk_cnt("frozen");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    for (int i = 0; i < NUM_LINES; i++) begin
      exp_cnt[i] = 0;
    end
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_enable();
    t_refuse();
    t_flag();
    t_reassert();
    t_region();
    t_collide();
    t_freeze();
    stop_test();
  end

  // Cuts a hang short well past the expected run of about 120 cycles.
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    $display("mismatch watchdog expected finish seen timeout");
    stop_test();
  end
endmodule
